// ### core/i2c_trig_regs.vh
/*
 * register offsets, field widths, reset values and condition codes of the
 * i2c trigger field matcher.
 * assumes inclusion by bare name from the core directory.
 */
`ifndef I2C_TRIG_REGS_VH
`define I2C_TRIG_REGS_VH

// register offsets (plain port, word index)
`define OFS_CONDITION     4'h0
`define OFS_ADDRESS       4'h1
`define OFS_FIRST_BYTE    4'h2
`define OFS_SECOND_BYTE   4'h3
`define OFS_STATUS        4'h4
`define OFS_MATCH_COUNT   4'h5

// condition codes for trigger_condition_select
`define COND_START        3'h0
`define COND_STOP         3'h1
`define COND_RESTART      3'h2
`define COND_NOACK        3'h3
`define COND_EEPROM       3'h4
`define COND_SEVEN_BIT    3'h5
`define COND_TEN_BIT      3'h6
`define COND_DATA_LENGTH  3'h7

// field widths
`define COND_W            3
`define ADDR_W            11
`define BYTE_W            9

// don't-care values
`define ADDR7_DONT_CARE   11'h080
`define ADDR10_DONT_CARE  11'h400
`define BYTE_DONT_CARE    9'h100

// reset values: all fields don't-care, condition ten-bit frame
`define RST_CONDITION     3'h6
`define RST_ADDRESS       11'h400
`define RST_FIRST_BYTE    9'h100
`define RST_SECOND_BYTE   9'h100

// status bit positions
`define ST_TRIGGER_BIT    0
`define ST_BUSY_BIT       1
`define ST_SUPPORTED_BIT  2

`endif

// ### core/i2c_frame_decoder.v
/*
 * watches synchronised scl and sda of an observed i2c bus and pulls out
 * each byte of a frame with its index since the start and the acknowledge
 * of its ninth bit; address forms and the read/write bit are left to the user.
 * assumes scl_s and sda_s already pass two flip-flops in the clock domain,
 * and that bus edges are far slower than the 50 ns clock.
 */
`timescale 1ns/1ps
module i2c_frame_decoder (
    input  wire        clock,         // 20 mhz system clock
    input  wire        rst_n,         // synchronous reset, active low
    input  wire        scl_s,         // synchronised scl
    input  wire        sda_s,         // synchronised sda
    output reg         frame_start,   // pulse on start or repeated start
    output reg         byte_done,     // pulse after each ninth bit
    output reg  [3:0]  byte_index,    // bytes seen since start, 0 based
    output reg  [7:0]  byte_value,    // last eight data bits
    output reg         byte_ack,      // ninth bit was low
    output reg         stop_seen      // pulse on stop
);

    reg        scl_d;
    reg        sda_d;
    reg  [3:0] bit_count;
    reg  [7:0] shift;

    wire scl_rise = scl_s & ~scl_d;
    wire sda_fall = ~sda_s & sda_d;
    wire sda_rise = sda_s & ~sda_d;

    // start and stop on sda edges while scl is high, bit sampling on scl rising edges
    always @(posedge clock) begin
        if (!rst_n) begin
            scl_d       <= 1'b1;
            sda_d       <= 1'b1;
            bit_count   <= 4'h0;
            shift       <= 8'h00;
            frame_start <= 1'b0;
            byte_done   <= 1'b0;
            byte_index  <= 4'h0;
            byte_value  <= 8'h00;
            byte_ack    <= 1'b0;
            stop_seen   <= 1'b0;
        end else begin
            scl_d       <= scl_s;
            sda_d       <= sda_s;
            frame_start <= 1'b0;
            byte_done   <= 1'b0;
            stop_seen   <= 1'b0;
            if (scl_s && scl_d && sda_fall) begin
                frame_start <= 1'b1;
                bit_count   <= 4'h0;
                byte_index  <= 4'h0;
            end else if (scl_s && scl_d && sda_rise) begin
                stop_seen <= 1'b1;
                bit_count <= 4'h0;
            end else if (scl_rise) begin
                if (bit_count == 4'h8) begin
                    // ninth bit is the acknowledge slot
                    byte_done  <= 1'b1;
                    byte_value <= shift;
                    byte_ack   <= ~sda_s;
                    bit_count  <= 4'h0;
                end else begin
                    shift     <= {shift[6:0], sda_s};
                    bit_count <= bit_count + 4'h1;
                end
            end
            // index advances one cycle after the byte pulse
            if (byte_done && byte_index != 4'hf)
                byte_index <= byte_index + 4'h1;
        end
    end

endmodule

// ### core/i2c_trigger_field_matcher.v
/*
 * i2c trigger field matcher: compares address and data fields of frames
 * on an observed i2c bus against software values and raises a trigger.
 * stored values are clamped on write, so a readback is always legal; the
 * address clamp follows the condition at the write, so set it first.
 * a condition write drops a frame in progress, so no frame is judged
 * under two conditions.
 * only the address byte's acknowledge is checked; later nacks pass.
 * the ten-bit form is recognised on its 11110xx prefix with either r/w bit, no restart.
 * status reads clear the sticky trigger flag; a trigger in that cycle wins.
 * assumes the bus pins are asynchronous and the register port is
 * driven from the 20 mhz clock domain.
 */
// Operation
// - address value used only in seven or ten bit frame conditions; read back as stored.
// - address value accepts 0 up to two to the address length.
// - seven bit condition with address 128 ignores the address field.
// - ten bit condition with address 1024 ignores the address field.
// - first data byte compared in seven bit, ten bit and eeprom conditions.
// - first data value 0 through 256; 256 means don't-care.
// - second data byte compared only in address frame conditions; 256 means don't-care.
`timescale 1ns/1ps
`include "i2c_trig_regs.vh"
module i2c_trigger_field_matcher (
    input  wire        clock,         // 20 mhz system clock
    input  wire        rst_n,         // synchronous reset, active low
    input  wire [3:0]  address,       // register index
    input  wire [15:0] write_data,    // register write data
    input  wire        write_strobe,  // one-cycle write
    input  wire        read_strobe,   // one-cycle read
    output reg  [15:0] read_data,     // read data, cycle after strobe
    input  wire        scl,           // observed bus clock pin
    input  wire        sda,           // observed bus data pin
    output reg         trigger        // one-cycle trigger pulse
);

    // control registers
    reg  [`COND_W-1:0] trigger_condition_select;
    reg  [`ADDR_W-1:0] trigger_address_compare_value;
    reg  [`BYTE_W-1:0] trigger_first_byte_compare_value;
    reg  [`BYTE_W-1:0] trigger_second_byte_compare_value;
    reg                trigger_seen;
    reg  [15:0]        match_count;
    reg  [15:0]        status_word;

    // pin synchronisers
    reg                scl_meta;
    reg                scl_sync;
    reg                sda_meta;
    reg                sda_sync;

    // frame tracking
    reg                in_frame;
    reg                addr_ok;
    reg                first_ok;
    reg  [7:0]         first_addr_byte;
    reg                eeprom_read;

    wire               frame_start;
    wire               byte_done;
    wire [3:0]         byte_index;
    wire [7:0]         byte_value;
    wire               byte_ack;
    wire               stop_seen;

    // top five bits of the first byte of a ten-bit address
    localparam [4:0]   TEN_PREFIX = 5'h1e;

    // byte equality, or true when the stored value is the don't-care code
    function byte_match;
        input [`BYTE_W-1:0] stored;
        input [7:0]         seen;
        begin
            byte_match = (stored == `BYTE_DONT_CARE) || (stored[7:0] == seen);
        end
    endfunction

    // clamp a written address into its legal range for the condition
    function [`ADDR_W-1:0] addr_clamp;
        input [`COND_W-1:0] cond;
        input [15:0]        value;
        begin
            if (cond == `COND_SEVEN_BIT && value > {5'h00, `ADDR7_DONT_CARE})
                addr_clamp = `ADDR7_DONT_CARE;
            else if (value > {5'h00, `ADDR10_DONT_CARE})
                addr_clamp = `ADDR10_DONT_CARE;
            else
                addr_clamp = value[`ADDR_W-1:0];
        end
    endfunction

    // clamp a written byte value to 0..256
    function [`BYTE_W-1:0] byte_clamp;
        input [15:0] value;
        begin
            if (value > {7'h00, `BYTE_DONT_CARE})
                byte_clamp = `BYTE_DONT_CARE;
            else
                byte_clamp = value[`BYTE_W-1:0];
        end
    endfunction

    wire cond_seven  = (trigger_condition_select == `COND_SEVEN_BIT);
    wire cond_ten    = (trigger_condition_select == `COND_TEN_BIT);
    wire cond_eeprom = (trigger_condition_select == `COND_EEPROM);
    wire cond_addr   = cond_seven | cond_ten;
    wire supported   = cond_addr | cond_eeprom;

    // a condition write in mid-frame abandons that frame
    wire cond_write  = write_strobe && (address == `OFS_CONDITION);

    // don't-care on the address field per condition
    wire addr_any = (cond_seven && trigger_address_compare_value == `ADDR7_DONT_CARE)
                 || (cond_ten && trigger_address_compare_value == `ADDR10_DONT_CARE);

    // ten-bit address from the 11110xx prefix and the following byte
    wire [9:0] ten_addr  = {first_addr_byte[2:1], byte_value};
    wire       ten_form  = (first_addr_byte[7:3] == TEN_PREFIX);

    // two flip-flops before any logic sees the pin; idle high as with pull-ups
    always @(posedge clock) begin
        if (!rst_n) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
        end else begin
            scl_meta <= scl;
            scl_sync <= scl_meta;
        end
    end

    // sda takes the same two stages, so start and stop keep their order
    always @(posedge clock) begin
        if (!rst_n) begin
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end else begin
            sda_meta <= sda;
            sda_sync <= sda_meta;
        end
    end

    // byte framing of the synchronised bus
    i2c_frame_decoder u_decoder (
        .clock       (clock),
        .rst_n       (rst_n),
        .scl_s       (scl_sync),
        .sda_s       (sda_sync),
        .frame_start (frame_start),
        .byte_done   (byte_done),
        .byte_index  (byte_index),
        .byte_value  (byte_value),
        .byte_ack    (byte_ack),
        .stop_seen   (stop_seen)
    );

    // software registers; values are clamped so the stored range stays legal
    always @(posedge clock) begin
        if (!rst_n) begin
            trigger_condition_select          <= `RST_CONDITION;
            trigger_address_compare_value     <= `RST_ADDRESS;
            trigger_first_byte_compare_value  <= `RST_FIRST_BYTE;
            trigger_second_byte_compare_value <= `RST_SECOND_BYTE;
        end else if (write_strobe) begin
            if (address == `OFS_CONDITION)
                trigger_condition_select <= write_data[`COND_W-1:0];
            else if (address == `OFS_ADDRESS)
                trigger_address_compare_value <=
                    addr_clamp(trigger_condition_select, write_data);
            else if (address == `OFS_FIRST_BYTE)
                trigger_first_byte_compare_value <= byte_clamp(write_data);
            else if (address == `OFS_SECOND_BYTE)
                trigger_second_byte_compare_value <= byte_clamp(write_data);
        end
    end

    // frame matching: each byte updates running verdicts, trigger on the last field
    always @(posedge clock) begin
        if (!rst_n) begin
            in_frame        <= 1'b0;
            addr_ok         <= 1'b0;
            first_ok        <= 1'b0;
            first_addr_byte <= 8'h00;
            eeprom_read     <= 1'b0;
            trigger         <= 1'b0;
        end else begin
            trigger <= 1'b0;
            // a new start always restarts the verdicts, even inside a frame
            if (frame_start) begin
                in_frame <= 1'b1;
                addr_ok  <= 1'b0;
                first_ok <= 1'b0;
            end else if (stop_seen) begin
                in_frame <= 1'b0;
            end else if (cond_write) begin
                in_frame <= 1'b0;
            end else if (byte_done && in_frame) begin
                case (byte_index)
                4'h0: begin
                    // address byte: 7-bit address with r/w, or 10-bit prefix
                    first_addr_byte <= byte_value;
                    eeprom_read     <= byte_value[0];
                    if (!byte_ack)
                        in_frame <= 1'b0;          // no ack: frame not well formed
                    else if (cond_seven)
                        addr_ok <= addr_any
                            || (trigger_address_compare_value[6:0] == byte_value[7:1]);
                    else if (cond_eeprom)
                        addr_ok <= 1'b1;           // control byte acked; address not compared
                end
                4'h1: begin
                    // second byte: low eight address bits, else first data
                    if (cond_ten) begin
                        addr_ok <= ten_form && (addr_any
                            || trigger_address_compare_value[9:0] == ten_addr);
                    end else begin
                        first_ok <= byte_match(trigger_first_byte_compare_value, byte_value);
                        if (cond_eeprom && addr_ok && eeprom_read
                            && byte_match(trigger_first_byte_compare_value, byte_value)) begin
                            trigger  <= 1'b1;      // eeprom ends at its data byte
                            in_frame <= 1'b0;
                        end
                    end
                end
                4'h2: begin
                    // third byte: ten-bit first data, else seven-bit second data
                    if (cond_ten)
                        first_ok <= byte_match(trigger_first_byte_compare_value, byte_value);
                    else if (cond_seven && addr_ok && first_ok
                             && byte_match(trigger_second_byte_compare_value, byte_value)) begin
                        trigger  <= 1'b1;
                        in_frame <= 1'b0;
                    end
                end
                4'h3: begin
                    // fourth byte: ten-bit second data, frame ends either way
                    if (cond_ten && addr_ok && first_ok
                        && byte_match(trigger_second_byte_compare_value, byte_value))
                        trigger <= 1'b1;
                    in_frame <= 1'b0;
                end
                default: in_frame <= 1'b0;
                endcase
            end
        end
    end

    // sticky trigger seen: a trigger in the clearing read's cycle wins
    always @(posedge clock) begin
        if (!rst_n) begin
            trigger_seen <= 1'b0;
        end else if (trigger) begin
            trigger_seen <= 1'b1;
        end else if (read_strobe && address == `OFS_STATUS) begin
            trigger_seen <= 1'b0;
        end
    end

    // match counter saturates rather than wrapping to a misleading low count
    always @(posedge clock) begin
        if (!rst_n) begin
            match_count <= 16'h0000;
        end else if (trigger && match_count != 16'hffff) begin
            match_count <= match_count + 16'h0001;
        end
    end

    // status word from its named bit positions
    always @* begin
        status_word                    = 16'h0000;
        status_word[`ST_TRIGGER_BIT]   = trigger_seen;
        status_word[`ST_BUSY_BIT]      = in_frame;
        status_word[`ST_SUPPORTED_BIT] = supported;
    end

    // readback, one cycle after the read strobe; unmapped reads zero
    always @(posedge clock) begin
        if (!rst_n) begin
            read_data <= 16'h0000;
        end else if (read_strobe) begin
            if (address == `OFS_CONDITION)
                read_data <= {13'h0000, trigger_condition_select};
            else if (address == `OFS_ADDRESS)
                read_data <= {5'h00, trigger_address_compare_value};
            else if (address == `OFS_FIRST_BYTE)
                read_data <= {7'h00, trigger_first_byte_compare_value};
            else if (address == `OFS_SECOND_BYTE)
                read_data <= {7'h00, trigger_second_byte_compare_value};
            else if (address == `OFS_STATUS)
                read_data <= status_word;
            else if (address == `OFS_MATCH_COUNT)
                read_data <= match_count;
            else
                read_data <= 16'h0000;
        end else begin
            read_data <= 16'h0000;
        end
    end

endmodule

// ### sim/i2c_trigger_field_matcher_chk.sv
/* port checker of the i2c trigger field matcher: readback, clamps, trigger shape.
   assumes the plain register port and one clock domain. */
`timescale 1ns/1ps
`include "i2c_trig_regs.vh"
module i2c_trigger_field_matcher_chk (
    input wire        clock,        // system clock
    input wire        rst_n,        // sync reset, active low
    input wire [3:0]  address,      // register index
    input wire [15:0] write_data,   // write data
    input wire        write_strobe, // write pulse
    input wire        read_strobe,  // read pulse
    input wire [15:0] read_data,    // read data
    input wire        scl,          // observed bus clock
    input wire        sda,          // observed bus data
    input wire        trigger       // trigger pulse
);
    reg [2:0]  last_cond;
    reg [15:0] last_addr;
    reg [15:0] last_first;
    reg [15:0] last_second;
    reg [7:0]  scl_age;
    reg        scl_d;
    // shadow of stored values; the address clamp follows the condition at the write
    always @(posedge clock) begin
        if (!rst_n) begin
            last_cond <= `RST_CONDITION;
            last_addr <= 16'h0400;
            last_first <= 16'h0100;
            last_second <= 16'h0100;
        end else if (write_strobe) begin
            case (address)
                `OFS_CONDITION: last_cond <= write_data[2:0];
                `OFS_ADDRESS: last_addr <= (last_cond == `COND_SEVEN_BIT) ?
                    ((write_data > 16'h0080) ? 16'h0080 : write_data) :
                    ((write_data > 16'h0400) ? 16'h0400 : write_data);
                `OFS_FIRST_BYTE: last_first <= (write_data > 16'h0100) ? 16'h0100 : write_data;
                `OFS_SECOND_BYTE: last_second <= (write_data > 16'h0100) ? 16'h0100 : write_data;
                default: ;
            endcase
        end
    end
    // cycles since scl last rose, saturating
    always @(posedge clock) begin
        scl_d <= scl;
        if (!rst_n || (scl && !scl_d))
            scl_age <= 8'h00;
        else if (scl_age != 8'hff)
            scl_age <= scl_age + 8'h01;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_read_idle: assert property (!read_strobe |=> read_data == 16'h0000)
        else $error("read data not zero outside a read");
    chk_unmapped_zero: assert property (read_strobe && address > `OFS_MATCH_COUNT |=> read_data == 16'h0000)
        else $error("unmapped index read not zero");
    chk_cond_readback: assert property (read_strobe && address == `OFS_CONDITION
        |=> read_data == {13'h0000, last_cond}) else $error("condition readback wrong");
    chk_addr_readback: assert property (read_strobe && address == `OFS_ADDRESS
        |=> read_data == last_addr) else $error("address readback wrong");
    chk_first_clamp: assert property (read_strobe && address == `OFS_FIRST_BYTE
        |=> read_data == last_first) else $error("first byte readback wrong");
    chk_second_clamp: assert property (read_strobe && address == `OFS_SECOND_BYTE
        |=> read_data == last_second) else $error("second byte readback wrong");
    chk_trig_pulse: assert property (trigger |=> !trigger) else $error("trigger longer than one cycle");
    chk_trig_timing: assert property (trigger |-> scl_age <= 8'd10)
        else $error("trigger far from an scl rise");
    chk_status_clear: assert property ((read_strobe && address == `OFS_STATUS && !trigger) ##1 !trigger ##1
        (read_strobe && address == `OFS_STATUS) |=> !read_data[0])
        else $error("sticky trigger flag not cleared by read");
    cov_trigger: cover property (trigger);
    cov_addr_read: cover property (read_strobe && address == `OFS_ADDRESS);
    cov_seven_set: cover property (write_strobe && address == `OFS_CONDITION && write_data[2:0] == `COND_SEVEN_BIT);
endmodule
bind i2c_trigger_field_matcher i2c_trigger_field_matcher_chk u_chk (.clock(clock), .rst_n(rst_n),
    .address(address), .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .scl(scl), .sda(sda), .trigger(trigger));

// ### sim/i2c_bus_model.sv
/* bus master and acknowledging target of the observed i2c bus.
   assumes the bench calls its tasks; lines idle high as with pull-ups. */
`timescale 1ns/1ps
module i2c_bus_model (
    input  wire clock, // paces every bus phase
    output reg  scl,   // bus clock, stands high between frames
    output reg  sda    // bus data, high when released
);
    // five clocks a phase, above the four the decoder needs
    localparam int PHASE = 5;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task wait_phase;
        repeat (PHASE) @(posedge clock);
    endtask
    // sda falls while scl is high
    task start_cond;
        sda <= 1'b0;
        wait_phase;
        scl <= 1'b0;
        wait_phase;
    endtask
    // data moves only while scl is low, so no false start or stop
    task put_bit(input b);
        sda <= b;
        wait_phase;
        scl <= 1'b1;
        wait_phase;
        scl <= 1'b0;
        wait_phase;
    endtask
    // msb first, then the ninth bit low for acknowledge
    task put_byte(input [7:0] b, input ack);
        integer i;
        for (i = 7; i >= 0; i--)
            put_bit(b[i]);
        put_bit(~ack);
    endtask
    task stop_cond;
        sda <= 1'b0;
        wait_phase;
        scl <= 1'b1;
        wait_phase;
        sda <= 1'b1;
        wait_phase;
    endtask
endmodule

// ### sim/i2c_trigger_field_matcher_bench.sv
/* self-checking bench of the i2c trigger field matcher.
   assumes the bus model drives the observed pins and the bench the register port. */
`timescale 1ns/1ps
`include "i2c_trig_regs.vh"
module i2c_trigger_field_matcher_bench;
    reg         clock = 1'b0;
    reg         rst_n = 1'b0;
    reg  [3:0]  address = 4'h0;
    reg  [15:0] write_data = 16'h0000;
    reg         write_strobe = 1'b0;
    reg         read_strobe = 1'b0;
    wire [15:0] read_data;
    wire        scl;
    wire        sda;
    wire        trigger;
    integer     fails = 0;
    integer     checks_done = 0;
    integer     cycles = 0;
    integer     trig_count = 0;
    integer     i;
    i2c_trigger_field_matcher dut (.clock(clock), .rst_n(rst_n), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data), .scl(scl), .sda(sda),
        .trigger(trigger));
    i2c_bus_model bus (.clock(clock), .scl(scl), .sda(sda));
    always #25 clock = ~clock;
    // trigger tally and hang guard; a run of about 6.4k cycles is expected
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (trigger === 1'b1)
            trig_count <= trig_count + 1;
        if (cycles == 40000) begin
            fails = fails + 1;
            conclude;
        end
    end
    task conclude;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task check(input string what, input [15:0] seen, input [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task rd_check(input [3:0] a, input [15:0] exp, input string what);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 check(what, read_data, exp);
    endtask
    // whole frame then stop; count trigger pulses it caused
    task frame(input [31:0] b, input integer n, input integer exp, input string what);
        integer base;
        integer k;
        base = trig_count;
        bus.start_cond;
        for (k = 0; k < n; k++)
            bus.put_byte(b[31-8*k -: 8], 1'b1);
        bus.stop_cond;
        repeat (10) @(posedge clock);
        check(what, 16'(trig_count - base), 16'(exp));
    endtask
    task test_regs;
        rd_check(`OFS_CONDITION, 16'h0006, "reset condition");
        rd_check(`OFS_ADDRESS, 16'h0400, "reset address");
        rd_check(`OFS_FIRST_BYTE, 16'h0100, "reset first");
        rd_check(`OFS_SECOND_BYTE, 16'h0100, "reset second");
        wr(4'h9, 16'h0055);
        rd_check(4'h9, 16'h0000, "unmapped");
        wr(`OFS_CONDITION, 16'h0005);
        wr(`OFS_ADDRESS, 16'h00c8);
        rd_check(`OFS_ADDRESS, 16'h0080, "seven clamp");
        wr(`OFS_CONDITION, 16'h0006);
        wr(`OFS_ADDRESS, 16'h044c);
        rd_check(`OFS_ADDRESS, 16'h0400, "ten clamp");
        wr(`OFS_ADDRESS, 16'h0122);
        rd_check(`OFS_ADDRESS, 16'h0122, "address kept");
        wr(`OFS_FIRST_BYTE, 16'h012c);
        rd_check(`OFS_FIRST_BYTE, 16'h0100, "first clamp");
        wr(`OFS_SECOND_BYTE, 16'h0101);
        rd_check(`OFS_SECOND_BYTE, 16'h0100, "second clamp");
        $display("test_regs done");
    endtask
    task test_seven;
        wr(`OFS_CONDITION, 16'h0005);
        wr(`OFS_ADDRESS, 16'h0050);
        wr(`OFS_FIRST_BYTE, 16'h0029);
        wr(`OFS_SECOND_BYTE, 16'h0041);
        frame(32'ha0294100, 3, 1, "seven match");
        frame(32'ha0294200, 3, 0, "seven data2 off");
        frame(32'ha2294100, 3, 0, "seven addr off");
        wr(`OFS_ADDRESS, 16'h0080);
        frame(32'ha2294100, 3, 1, "seven addr any");
        rd_check(`OFS_STATUS, 16'h0005, "sticky set");
        rd_check(`OFS_STATUS, 16'h0004, "sticky clear");
        $display("test_seven done");
    endtask
    task test_ten;
        wr(`OFS_CONDITION, 16'h0006);
        wr(`OFS_ADDRESS, 16'h0122);
        frame(32'hf2222941, 4, 1, "ten match");
        frame(32'hf2232941, 4, 0, "ten addr off");
        wr(`OFS_ADDRESS, 16'h0400);
        wr(`OFS_FIRST_BYTE, 16'h0100);
        frame(32'hf2237741, 4, 1, "ten any addr data");
        $display("test_ten done");
    endtask
    // the stored address 16'h0033 and second value are ignored here
    task test_eeprom;
        wr(`OFS_CONDITION, 16'h0004);
        wr(`OFS_ADDRESS, 16'h0033);
        wr(`OFS_FIRST_BYTE, 16'h0029);
        wr(`OFS_SECOND_BYTE, 16'h0055);
        frame(32'ha1290000, 2, 1, "eeprom match");
        frame(32'ha12a0000, 2, 0, "eeprom data off");
        $display("test_eeprom done");
    endtask
    task test_others;
        wr(`OFS_ADDRESS, 16'h0050);
        wr(`OFS_SECOND_BYTE, 16'h0041);
        for (i = 0; i < 8; i++) begin
            if (i < 4 || i == 7) begin
                wr(`OFS_CONDITION, i[15:0]);
                frame(32'ha0294100, 3, 0, "other condition");
            end
        end
        rd_check(`OFS_MATCH_COUNT, 16'h0005, "match count");
        $display("test_others done");
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        test_regs;
        test_seven;
        test_ten;
        test_eeprom;
        test_others;
        conclude;
    end
endmodule
